//--- core/scr_defines.svh
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// ****************************************************************
// Timing of the reference clock and the power-up wait.
// ****************************************************************

// Reference clock period in nanoseconds, 100 MHz.
`define SCR_REF_PERIOD_NS 10
// Least wait after configuration or master reset, in nanoseconds.
`define SCR_RST_WAIT_NS 500
// Wait in reference clock cycles, rounded up.
`define SCR_RST_WAIT_CYC ((`SCR_RST_WAIT_NS + `SCR_REF_PERIOD_NS - 1) / `SCR_REF_PERIOD_NS)

// ****************************************************************
// Default dividers for the derived clock enables, and the reset synchroniser depth.
// ****************************************************************

// Reference cycles per core clock tick.
`define SCR_CORE_DIV 2
// Reference cycles per secondary transmit user clock tick.
`define SCR_TX_HALF_DIV 4
// Reference cycles per quad PLL output clock tick.
`define SCR_PLL_DIV 2
// Reference cycles per quad PLL reference clock tick.
`define SCR_PLL_REF_DIV 1
// Stages in each reset synchroniser.
`define SCR_SYNC_STAGES 3

`endif

//--- core/scr_div.sv
`timescale 1ns/1ps
`include "scr_defines.svh"

// ****************************************************************
// Free-running divider giving a one-cycle enable pulse.
// ****************************************************************
module scr_div #(
	parameter int DIV = `SCR_CORE_DIV
) (
	input wire logic ref_clk,
	input wire logic rstn,
	output logic tick
);

	if (DIV < 1) $error("scr_div: DIV must be at least 1");

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic next_tick;

	// Count reference cycles and pulse on the last one.
	always_comb
	begin
		next_tick = (cnt == LAST);
		next_cnt = next_tick ? '0 : cnt + CW'(1);
	end

	// Register the counter and the pulse.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt <= '0;
			tick <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end

endmodule : scr_div

//--- core/scr_pkg.sv
// ****************************************************************
// Types shared by the shared clock and reset logic.
// ****************************************************************
package scr_pkg;

	// Clock enables that stand for the exported clocks.
	typedef struct packed {
		logic core;
		logic tx_half;
		logic rx_rec;
		logic pll;
		logic pll_ref;
	} scr_clk_t;

	// Synchronised reset outputs, all active high.
	typedef struct packed {
		logic datapath;
		logic core;
		logic tx_xcvr;
		logic rx_xcvr;
	} scr_rst_t;

	// Power-up sequence states.
	typedef enum logic [1:0] {
		SEQ_WAIT_COUNT,
		SEQ_WAIT_LOCK,
		SEQ_WAIT_DONE,
		SEQ_RUN
	} scr_seq_t;

endpackage : scr_pkg

//--- core/scr_rst_sync.sv
`timescale 1ns/1ps
`include "scr_defines.svh"

// ****************************************************************
// Reset synchroniser: asserts at once, releases on destination ticks.
// ****************************************************************
module scr_rst_sync #(
	parameter int STAGES = `SCR_SYNC_STAGES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic hold,
	output logic rst_out
);

	if (STAGES < 2) $error("scr_rst_sync: STAGES must be at least 2");

	logic [STAGES-1:0] pipe;
	logic [STAGES-1:0] next_pipe;

	// A hold request fills the chain; a tick shifts one release stage in.
	always_comb
	begin
		next_pipe = pipe;
		if (hold)
			next_pipe = '1;
		else if (clk_en)
			next_pipe = {pipe[STAGES-2:0], 1'b0};
	end

	// Master reset forces the chain asserted without a clock.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			pipe <= '1;
		else
			pipe <= next_pipe;
	end

	assign rst_out = pipe[STAGES-1];

	// Release happens only on a destination tick.
	rel_on_tick_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		$fell(rst_out) |-> $past(clk_en) && !$past(hold))
		else $error("reset released without a destination tick");

endmodule : scr_rst_sync

//--- core/scr_top.sv
`timescale 1ns/1ps
`include "scr_defines.svh"


// ****************************************************************
// Shared clock and reset sequencer.
// ****************************************************************
module scr_top #(
	parameter int CORE_DIV = `SCR_CORE_DIV,
	parameter int TX_HALF_DIV = `SCR_TX_HALF_DIV,
	parameter int PLL_DIV = `SCR_PLL_DIV,
	parameter int PLL_REF_DIV = `SCR_PLL_REF_DIV,
	parameter int STAGES = `SCR_SYNC_STAGES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic newer_family,
	input wire logic base_r,
	input wire logic pll_lock_pin,
	input wire logic tx_done_pin,
	input wire logic rx_done_pin,
	input wire logic rx_rec_clk_pin,
	output scr_pkg::scr_clk_t clk_q,
	output scr_pkg::scr_rst_t rst_q,
	output logic mgmt_reset,
	output logic quad_pll_locked_b,
	output logic quad_pll_clock_b,
	output logic quad_pll_refclock_b,
	output logic tx_user_clock_half,
	output logic tx_user_ready,
	output logic resetdone_combined,
	output logic reset_counter_done
);

	if (CORE_DIV < 1 || TX_HALF_DIV < 1 || PLL_DIV < 1 || PLL_REF_DIV < 1)
		$error("scr_top: dividers must be at least 1");

	localparam int WAIT_CYC = `SCR_RST_WAIT_CYC;
	localparam int CW = $clog2(WAIT_CYC + 1);
	localparam logic [CW-1:0] WAIT_LAST = CW'(WAIT_CYC);

	// ****************************************************************
	// Pin synchronisers.
	// ****************************************************************

	logic [5:0] pin_s1;
	logic [5:0] pin_s2;
	logic lock_s;
	logic tx_done_s;
	logic rx_done_s;
	logic rx_clk_s;
	logic newer_s;
	logic base_r_s;

	// Two flip-flops on every pin before any logic reads it.
	// The family strap stages start high, so the core reset cannot dip low after reset.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_s1 <= 6'h10;
			pin_s2 <= 6'h10;
		end
		else
		begin
			pin_s1 <= {base_r, newer_family, rx_rec_clk_pin, rx_done_pin, tx_done_pin,
				pll_lock_pin};
			pin_s2 <= pin_s1;
		end
	end

	assign {base_r_s, newer_s, rx_clk_s, rx_done_s, tx_done_s, lock_s} = pin_s2;

	// ****************************************************************
	// Clock enable dividers.
	// ****************************************************************

	logic core_tick;
	logic half_tick;
	logic pll_tick;
	logic ref_tick;

	// Core clock runs from reset on, independent of the sequence.
	scr_div #(.DIV(CORE_DIV)) u_core_div (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.tick(core_tick)
	);

	scr_div #(.DIV(TX_HALF_DIV)) u_half_div (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.tick(half_tick)
	);

	scr_div #(.DIV(PLL_DIV)) u_pll_div (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.tick(pll_tick)
	);

	scr_div #(.DIV(PLL_REF_DIV)) u_ref_div (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.tick(ref_tick)
	);

	// ****************************************************************
	// Power-up sequence and wait counter.
	// ****************************************************************

	scr_pkg::scr_seq_t state;
	scr_pkg::scr_seq_t next_state;
	logic [CW-1:0] wait_cnt;
	logic [CW-1:0] next_wait_cnt;
	logic rx_edge_prev;
	logic next_rx_edge_prev;
	logic pll_clk_gated;

	// Count out the wait, then wait for lock, then for both reset-dones.
	always_comb
	begin
		next_wait_cnt = wait_cnt;
		next_state = state;
		next_rx_edge_prev = rx_clk_s;
		if (wait_cnt != WAIT_LAST)
			next_wait_cnt = wait_cnt + CW'(1);
		unique case (state)
			scr_pkg::SEQ_WAIT_COUNT:
				if (wait_cnt == WAIT_LAST)
					next_state = scr_pkg::SEQ_WAIT_LOCK;
			scr_pkg::SEQ_WAIT_LOCK:
				if (lock_s)
					next_state = scr_pkg::SEQ_WAIT_DONE;
			scr_pkg::SEQ_WAIT_DONE:
				if (!lock_s)
					next_state = scr_pkg::SEQ_WAIT_LOCK;
				else if (tx_done_s && rx_done_s)
					next_state = scr_pkg::SEQ_RUN;
			scr_pkg::SEQ_RUN:
				if (!lock_s)
					next_state = scr_pkg::SEQ_WAIT_LOCK;
		endcase
	end

	// Master reset restarts the wait and the sequence.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= scr_pkg::SEQ_WAIT_COUNT;
			wait_cnt <= '0;
			rx_edge_prev <= 1'b0;
		end
		else
		begin
			state <= next_state;
			wait_cnt <= next_wait_cnt;
			rx_edge_prev <= next_rx_edge_prev;
		end
	end

	assign pll_clk_gated = pll_tick && lock_s;

	// ****************************************************************
	// Reset synchronisers.
	// ****************************************************************

	logic dp_en;
	logic dp_hold;
	logic tx_hold;
	logic rx_hold;
	logic dp_rst;
	logic core_rst;
	logic tx_rst;
	logic rx_rst;

	// Datapath ticks come from the secondary user clock only in that variant.
	assign dp_en = (newer_s && base_r_s) ? half_tick : core_tick;
	assign dp_hold = (state != scr_pkg::SEQ_RUN);
	assign tx_hold = (state == scr_pkg::SEQ_WAIT_COUNT);
	assign rx_hold = (state == scr_pkg::SEQ_WAIT_COUNT) || !lock_s;

	scr_rst_sync #(.STAGES(STAGES)) u_dp_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(dp_en),
		.hold(dp_hold),
		.rst_out(dp_rst)
	);

	scr_rst_sync #(.STAGES(STAGES)) u_core_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(core_tick),
		.hold(tx_hold),
		.rst_out(core_rst)
	);

	scr_rst_sync #(.STAGES(STAGES)) u_tx_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(core_tick),
		.hold(tx_hold),
		.rst_out(tx_rst)
	);

	scr_rst_sync #(.STAGES(STAGES)) u_rx_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(core_tick),
		.hold(rx_hold),
		.rst_out(rx_rst)
	);

	// ****************************************************************
	// Output registers.
	// ****************************************************************

	scr_pkg::scr_clk_t next_clk;
	scr_pkg::scr_rst_t next_rst;
	logic next_ready;
	logic next_done;
	logic next_cnt_done;

	// Domain-bound outputs update only on their own clock's tick.
	always_comb
	begin
		next_clk.core = core_tick;
		next_clk.tx_half = half_tick;
		next_clk.rx_rec = rx_clk_s && !rx_edge_prev;
		next_clk.pll = pll_clk_gated;
		next_clk.pll_ref = ref_tick;
		next_rst.datapath = dp_rst;
		next_rst.core = newer_s && core_rst;
		next_rst.tx_xcvr = tx_rst;
		next_rst.rx_xcvr = rx_rst;
		next_ready = half_tick ? lock_s : tx_user_ready;
		next_done = core_tick ? (tx_done_s && rx_done_s) : resetdone_combined;
		next_cnt_done = core_tick ? (wait_cnt == WAIT_LAST) : reset_counter_done;
	end

	// Every output comes from a flip-flop with a defined reset value.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			clk_q <= '0;
			rst_q <= '1;
			mgmt_reset <= 1'b1;
			quad_pll_locked_b <= 1'b0;
			quad_pll_clock_b <= 1'b0;
			quad_pll_refclock_b <= 1'b0;
			tx_user_clock_half <= 1'b0;
			tx_user_ready <= 1'b0;
			resetdone_combined <= 1'b0;
			reset_counter_done <= 1'b0;
		end
		else
		begin
			clk_q <= next_clk;
			rst_q <= next_rst;
			mgmt_reset <= core_rst;
			quad_pll_locked_b <= lock_s;
			quad_pll_clock_b <= next_clk.pll;
			quad_pll_refclock_b <= next_clk.pll_ref;
			tx_user_clock_half <= next_clk.tx_half;
			tx_user_ready <= next_ready;
			resetdone_combined <= next_done;
			reset_counter_done <= next_cnt_done;
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence s_count_full;
		wait_cnt == WAIT_LAST;
	endsequence

	sequence s_core_tick;
		core_tick;
	endsequence

	cnt_done_wait_a: assert property (
		$rose(reset_counter_done) |-> $past(wait_cnt == WAIT_LAST))
		else $error("counter done before the wait elapsed");

	cnt_done_rise_a: assert property (
		s_count_full ##0 s_core_tick |=> reset_counter_done)
		else $error("counter done missed a core tick");

	tx_rst_held_a: assert property (
		!reset_counter_done && $past(!reset_counter_done) |-> rst_q.tx_xcvr)
		else $error("transmit reset released during the wait");

	rx_rst_lock_a: assert property (
		$fell(rst_q.rx_xcvr) |-> $past(lock_s, 2))
		else $error("receive reset released without lock");

	done_merge_a: assert property (
		$rose(resetdone_combined) |-> $past(tx_done_s && rx_done_s && core_tick))
		else $error("combined done rose without both dones");

	dp_rst_drop_a: assert property (
		$fell(rst_q.datapath) |-> $past(state == scr_pkg::SEQ_RUN, 2))
		else $error("datapath reset released before sequence completed");

	core_rst_fam_a: assert property (
		$past(!newer_s) |-> !rst_q.core)
		else $error("core reset driven on the older family");

	ready_lock_a: assert property (
		$changed(tx_user_ready) |-> $past(half_tick) && tx_user_ready == $past(lock_s))
		else $error("user ready changed off its clock or against lock");

	core_free_a: assert property (
		1'b1 |-> ##[0:8] clk_q.core)
		else $error("core clock enable stopped");

	pll_clk_lock_a: assert property (
		quad_pll_clock_b |-> $past(lock_s))
		else $error("quad PLL clock ran without lock");

	mgmt_rst_a: assert property (
		$rose(rstn) |-> mgmt_reset [*2])
		else $error("management reset not held after master reset");

endmodule : scr_top

//--- test/scr_xcvr_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Transceiver stand-in: PLL lock, reset-done flags, recovered clock.
// ****************************************************************
module scr_xcvr_model #(
	parameter int DONE_DLY = 6,
	parameter int RX_HALF = 4
) (
	input wire logic ref_clk,
	input wire logic lock_cmd,
	input wire logic tx_ok,
	input wire logic rx_ok,
	input wire logic rx_run,
	input wire logic tx_rst,
	input wire logic rx_rst,
	output logic pll_lock = 1'b0,
	output logic tx_done = 1'b0,
	output logic rx_done = 1'b0,
	output logic rx_clk = 1'b0
);
	int tc = 0;
	int rc = 0;
	int kc = 0;

	// Pins move on the falling edge; a done flag needs lock and a released reset.
	always @(negedge ref_clk)
	begin
		pll_lock <= lock_cmd;
		tc <= (tx_rst || !lock_cmd || !tx_ok) ? 0 : ((tc < DONE_DLY) ? tc + 1 : tc);
		rc <= (rx_rst || !lock_cmd || !rx_ok) ? 0 : ((rc < DONE_DLY) ? rc + 1 : rc);
		tx_done <= (tc == DONE_DLY);
		rx_done <= (rc == DONE_DLY);
		kc <= rx_run ? (kc + 1) % RX_HALF : 0;
		rx_clk <= rx_run ? ((kc == RX_HALF - 1) ^ rx_clk) : 1'b0;
	end

endmodule : scr_xcvr_model

//--- test/test_scr_top.sv
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench for the shared clock and reset sequencer.
// ****************************************************************
module test_scr_top;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic newer_family = 1'b1;
	logic base_r = 1'b1;
	logic lock_cmd = 1'b0;
	logic tx_ok = 1'b0;
	logic rx_ok = 1'b0;
	logic rx_run = 1'b0;
	logic pll_lock_pin;
	logic tx_done_pin;
	logic rx_done_pin;
	logic rx_rec_clk_pin;
	scr_pkg::scr_clk_t clk_q;
	scr_pkg::scr_rst_t rst_q;
	logic mgmt_reset;
	logic quad_pll_locked_b;
	logic quad_pll_clock_b;
	logic quad_pll_refclock_b;
	logic tx_user_clock_half;
	logic tx_user_ready;
	logic resetdone_combined;
	logic reset_counter_done;
	int bad_count = 0;
	int n_checks = 0;
	logic [8:0] fl;
	logic [7:0] pv;

	// Level flags and tick pulses gathered for the polling tasks.
	assign fl = {rst_q, mgmt_reset, quad_pll_locked_b, tx_user_ready, resetdone_combined,
		reset_counter_done};
	assign pv = {clk_q, quad_pll_clock_b, quad_pll_refclock_b, tx_user_clock_half};

	// Free-running 100 MHz clock.
	always #5 ref_clk = ~ref_clk;

	scr_top i_dut (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.newer_family(newer_family),
		.base_r(base_r),
		.pll_lock_pin(pll_lock_pin),
		.tx_done_pin(tx_done_pin),
		.rx_done_pin(rx_done_pin),
		.rx_rec_clk_pin(rx_rec_clk_pin),
		.clk_q(clk_q),
		.rst_q(rst_q),
		.mgmt_reset(mgmt_reset),
		.quad_pll_locked_b(quad_pll_locked_b),
		.quad_pll_clock_b(quad_pll_clock_b),
		.quad_pll_refclock_b(quad_pll_refclock_b),
		.tx_user_clock_half(tx_user_clock_half),
		.tx_user_ready(tx_user_ready),
		.resetdone_combined(resetdone_combined),
		.reset_counter_done(reset_counter_done)
	);

	scr_xcvr_model i_xcvr (
		.ref_clk(ref_clk),
		.lock_cmd(lock_cmd),
		.tx_ok(tx_ok),
		.rx_ok(rx_ok),
		.rx_run(rx_run),
		.tx_rst(rst_q.tx_xcvr),
		.rx_rst(rst_q.rx_xcvr),
		.pll_lock(pll_lock_pin),
		.tx_done(tx_done_pin),
		.rx_done(rx_done_pin),
		.rx_clk(rx_rec_clk_pin)
	);

	// ****************************************************************
	// Shared helpers.
	// ****************************************************************

	// Compares a value and counts the outcome.
	task check(input string name, input logic [16:0] seen, input logic [16:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error: %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Waits a bounded number of cycles for a flag, then compares it.
	task wait_flag(input int idx, input logic val, input int max, input string name);
		for (int i = 0; i < max && fl[idx] !== val; i++) @(negedge ref_clk);
		check(name, 17'(fl[idx]), 17'(val));
	endtask : wait_flag

	// Counts the pulses of one tick output over a window.
	task count_ticks(input int idx, input int cyc, output int n);
		n = 0;
		repeat (cyc)
		begin
			@(negedge ref_clk);
			n += int'(pv[idx] === 1'b1);
		end
	endtask : count_ticks

	// Prints the counts and the verdict, then ends the run.
	task give_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	// ****************************************************************
	// Scenarios.
	// ****************************************************************

	// Values held while reset is low, then release.
	task t_reset();
		check("reset outputs", {clk_q, rst_q, mgmt_reset, quad_pll_locked_b, quad_pll_clock_b,
			quad_pll_refclock_b, tx_user_clock_half, tx_user_ready, resetdone_combined,
			reset_counter_done}, {5'h00, 4'hF, 1'h1, 7'h00});
		rstn = 1'b1;
		$display("Test reset finished");
	endtask : t_reset

	// Wait counter with no PLL lock yet.
	task t_count();
		repeat (49) @(negedge ref_clk);
		check("counter early", 17'(reset_counter_done), 17'h0);
		check("resets held", 17'({rst_q.core, mgmt_reset}), 17'h3);
		wait_flag(0, 1'b1, 30, "counter done");
		check("rx reset unlocked", 17'(rst_q.rx_xcvr), 17'h1);
		wait_flag(6, 1'b0, 40, "tx reset");
		$display("Test count finished");
	endtask : t_count

	// Lock arrives: exported lock, ready, rx reset and clock rates.
	task automatic t_lock();
		int n;
		int idxs[7] = '{7, 6, 0, 4, 2, 3, 1};
		int exps[7] = '{10, 5, 5, 10, 10, 20, 20};
		lock_cmd <= 1'b1;
		wait_flag(3, 1'b1, 6, "pll locked");
		wait_flag(2, 1'b1, 12, "tx user ready");
		wait_flag(5, 1'b0, 30, "rx reset");
		for (int i = 0; i < 7; i++)
		begin
			count_ticks(idxs[i], 20, n);
			check("tick count", 17'(n), 17'(exps[i]));
		end
		$display("Test lock finished");
	endtask : t_lock

	// One done flag alone, then both; datapath and management release.
	task t_done();
		tx_ok <= 1'b1;
		repeat (30) @(negedge ref_clk);
		check("done one side", 17'(resetdone_combined), 17'h0);
		rx_ok <= 1'b1;
		wait_flag(1, 1'b1, 30, "combined done");
		wait_flag(8, 1'b0, 40, "datapath reset");
		wait_flag(4, 1'b0, 40, "mgmt reset");
		check("core reset newer", 17'(rst_q.core), 17'h0);
		$display("Test done finished");
	endtask : t_done

	// Recovered clock running, then standing still.
	task t_rxclk();
		int n;
		rx_run <= 1'b1;
		count_ticks(5, 80, n);
		check("rx ticks", 17'(n >= 9 && n <= 11), 17'h1);
		rx_run <= 1'b0;
		repeat (6) @(negedge ref_clk);
		count_ticks(5, 20, n);
		check("rx idle ticks", 17'(n), 17'h0);
		$display("Test rxclk finished");
	endtask : t_rxclk

	// Loss of lock pulls the dependent resets and flags back.
	task t_loss();
		lock_cmd <= 1'b0;
		wait_flag(5, 1'b1, 6, "rx reset on loss");
		wait_flag(8, 1'b1, 6, "datapath on loss");
		wait_flag(3, 1'b0, 6, "lock lost");
		wait_flag(2, 1'b0, 12, "tx not ready");
		wait_flag(1, 1'b0, 20, "done dropped");
		$display("Test loss finished");
	endtask : t_loss

	// Mid-run reset asserts at once; older family keeps the core reset low.
	task t_older();
		rstn = 1'b0;
		newer_family = 1'b0;
		base_r = 1'b0;
		lock_cmd <= 1'b1;
		#1;
		check("async reset", 17'({rst_q, mgmt_reset}), 17'h1F);
		repeat (3) @(negedge ref_clk);
		rstn = 1'b1;
		wait_flag(8, 1'b0, 200, "datapath older");
		check("core reset older", 17'(rst_q.core), 17'h0);
		wait_flag(1, 1'b1, 40, "combined done older");
		$display("Test older finished");
	endtask : t_older

	// Main sequence.
	initial
	begin
		repeat (3) @(negedge ref_clk);
		t_reset();
		t_count();
		t_lock();
		t_done();
		t_rxclk();
		t_loss();
		t_older();
		give_verdict();
	end

	// Watchdog for a hung run.
	initial
	begin
		#100000;
		bad_count++;
		give_verdict();
	end

endmodule : test_scr_top
